// file: design/gsbt_pkg.sv
// Shared constants, register map and carrier types for the gated sixteen-bit timer.
package gsbt_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_GATE_CONTROL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER_LOW = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER_HIGH = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

    // Timer control field positions.
    localparam int TC_ON_BIT = 0;
    localparam int TC_SYNC_DISABLE_BIT = 2;
    localparam int TC_EXT_CLOCK_BIT = 3;
    localparam int TC_PRESCALE_LSB = 4;
    // Gate control field positions.
    localparam int GC_SOURCE_LSB = 0;
    localparam int GC_POLARITY_BIT = 6;
    localparam int GC_ENABLE_BIT = 7;
    // Status field positions.
    localparam int ST_OVERFLOW_BIT = 0;

    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COUNTER_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        GSBT_GATE_PIN = 2'h0,
        GSBT_GATE_EIGHT_BIT_OVF = 2'h1,
        GSBT_GATE_PERIOD_MATCH = 2'h2,
        GSBT_GATE_WATCHDOG_OVF = 2'h3
    } gsbt_gate_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gsbt_bus_req_t;

    typedef struct packed {
        logic gate_pin;
        logic eight_bit_timer_ovf;
        logic period_timer_match;
        logic watchdog_ovf;
    } gsbt_gate_in_t;
endpackage

// file: design/gsbt_sync3.sv
// Three-stage input synchroniser with agreement on the last two stages.
`timescale 1ns/1ps
module gsbt_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] q_ff;

    // A zero-width synchroniser would silently drop the pins it is meant to guard.
    if (WIDTH < 1) begin : g_bad_width
        $error("gsbt_sync3: WIDTH must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A bit changes only once stages two and three agree, filtering a one-cycle glitch.
    for (genvar i = 0; i < WIDTH; i++) begin : g_agree
        always_ff @(posedge clk) begin
            if (rst) begin
                q_ff[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
                q_ff[i] <= s3_ff[i];
            end
        end
    end

    assign q = q_ff;
endmodule

// file: design/gsbt_timer.sv
// Gated sixteen-bit timer with prescaler, gate selection and register port.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Operation
// - Prescaler divides the timer clock by 1, 2, 4 or 8 per select field.
// - Prescale counter is hidden; any counter byte write clears it.
// - Sync-disable bit bypasses synchronisation of the external clock input.
// - Async external counting continues in sleep; overflow wakes the processor.
// - Mode switches may drop or add one increment.
// - Reading either counter byte during async counting returns a coherent value.
// - Gate enable clear counts freely; set lets the selected gate control counting.
// - Active gate increments on rising clock edges; inactive gate holds count.
// - Gate polarity sets the active level, 0 low, 1 high.
// - Gate source select: pin, eight-bit overflow, period match, watchdog overflow.
// - One polarity setting applies to every selected gate source.
module gsbt_timer
    import gsbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gsbt_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic counter_clock_source,
    input wire gsbt_gate_in_t gate_in,
    input wire logic sleep,
    output logic overflow_flag,
    output logic wake
);
    logic [7:0] timer_control_reg_ff;
    logic [7:0] gate_control_reg_ff;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic overflow_ff;
    logic [2:0] prescale_ff;
    logic [7:0] rdata_ff;
    logic [1:0] sync_in;
    logic [1:0] sync_out;
    logic ext_clk_s;
    logic gate_raw_s;
    logic ext_prev_ff;
    logic raw_tap_ff;
    logic raw_prev_ff;
    logic ext_edge;
    logic tick;
    logic gate_selected;
    logic gate_ok;
    logic inc;
    logic wr_count;

    wire timer_on = timer_control_reg_ff[TC_ON_BIT];
    wire sync_disable = timer_control_reg_ff[TC_SYNC_DISABLE_BIT];
    wire ext_select = timer_control_reg_ff[TC_EXT_CLOCK_BIT];
    wire [1:0] prescale_select = timer_control_reg_ff[TC_PRESCALE_LSB +: 2];
    wire gate_enable = gate_control_reg_ff[GC_ENABLE_BIT];
    wire gate_polarity = gate_control_reg_ff[GC_POLARITY_BIT];
    wire [1:0] gate_source_select = gate_control_reg_ff[GC_SOURCE_LSB +: 2];

    function automatic logic hit(input gsbt_bus_req_t r, input logic [ADDR_W-1:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    assign wr_count = hit(bus_req, ADDR_COUNTER_LOW) || hit(bus_req, ADDR_COUNTER_HIGH);

    // Pins from outside the clock domain: external clock and the gate pin.
    assign sync_in = {gate_in.gate_pin, counter_clock_source};

    gsbt_sync3 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d(sync_in),
        .q(sync_out)
    );

    assign ext_clk_s = sync_out[0];
    assign gate_raw_s = sync_out[1];

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_control_reg_ff <= TIMER_CONTROL_RESET;
        end else if (hit(bus_req, ADDR_TIMER_CONTROL)) begin
            timer_control_reg_ff <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_control_reg_ff <= GATE_CONTROL_RESET;
        end else if (hit(bus_req, ADDR_GATE_CONTROL)) begin
            gate_control_reg_ff <= bus_req.wdata;
        end
    end

    // In asynchronous mode the edge is taken from a single capture stage, standing in for
    // the unsynchronised ripple path; it skips the filter so it keeps up with a faster
    // external clock at the cost of metastability margin.
    always_ff @(posedge clk) begin
        if (rst) begin
            raw_tap_ff <= 1'b0;
            raw_prev_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            raw_tap_ff <= counter_clock_source;
            raw_prev_ff <= raw_tap_ff;
            ext_prev_ff <= ext_clk_s;
        end
    end

    always_comb begin
        if (!ext_select) begin
            ext_edge = 1'b1;
        end else if (sync_disable) begin
            ext_edge = raw_tap_ff && !raw_prev_ff;
        end else begin
            ext_edge = ext_clk_s && !ext_prev_ff;
        end
    end

    // Switching between the two edge paths may drop or add one edge.

    always_ff @(posedge clk) begin
        if (rst || wr_count) begin
            prescale_ff <= 3'h0;
        end else if (timer_on && ext_edge) begin
            prescale_ff <= prescale_ff + 3'h1;
        end
    end

    always_comb begin
        unique case (prescale_select)
            2'h0: tick = ext_edge;
            2'h1: tick = ext_edge && (prescale_ff[0] == 1'b1);
            2'h2: tick = ext_edge && (prescale_ff[1:0] == 2'h3);
            2'h3: tick = ext_edge && (prescale_ff == 3'h7);
        endcase
    end

    always_comb begin
        unique case (gsbt_gate_src_t'(gate_source_select))
            GSBT_GATE_PIN: gate_selected = gate_raw_s;
            GSBT_GATE_EIGHT_BIT_OVF: gate_selected = gate_in.eight_bit_timer_ovf;
            GSBT_GATE_PERIOD_MATCH: gate_selected = gate_in.period_timer_match;
            GSBT_GATE_WATCHDOG_OVF: gate_selected = gate_in.watchdog_ovf;
        endcase
    end

    // Polarity compares the selected source for every source alike.
    assign gate_ok = !gate_enable || (gate_selected == gate_polarity);

    // The sleep input only gates wake: counting never depends on it.
    assign inc = timer_on && tick && gate_ok;

    // A byte write wins over a coincident increment in its own byte only; software should stop the counter first.
    always_comb begin
        nxt_count = count_ff;
        if (inc) begin
            nxt_count = count_ff + 16'h0001;
        end
        if (hit(bus_req, ADDR_COUNTER_LOW)) begin
            nxt_count[7:0] = bus_req.wdata;
        end
        if (hit(bus_req, ADDR_COUNTER_HIGH)) begin
            nxt_count[15:8] = bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= COUNTER_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Overflow is sticky; writing one clears it, and a new overflow wins over the clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_ff <= 1'b0;
        end else if (inc && count_ff == COUNTER_MAX) begin
            overflow_ff <= 1'b1;
        end else if (hit(bus_req, ADDR_STATUS) && bus_req.wdata[ST_OVERFLOW_BIT]) begin
            overflow_ff <= 1'b0;
        end
    end

    // Reads sample the clock-domain copy of the count, so a byte is never torn.
    // Overflow between two byte reads is left to software.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_TIMER_CONTROL: rdata_ff <= timer_control_reg_ff;
                ADDR_GATE_CONTROL: rdata_ff <= gate_control_reg_ff;
                ADDR_COUNTER_LOW: rdata_ff <= count_ff[7:0];
                ADDR_COUNTER_HIGH: rdata_ff <= count_ff[15:8];
                ADDR_STATUS: rdata_ff <= {7'h00, overflow_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata = rdata_ff;
    assign overflow_flag = overflow_ff;
    assign wake = overflow_ff && sleep;
endmodule

// file: tb/gsbt_monitor.sv
// Port checker for the gated sixteen-bit timer.
`timescale 1ns/1ps
module gsbt_monitor
    import gsbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gsbt_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire gsbt_gate_in_t gate_in,
    input wire logic sleep,
    input wire logic overflow_flag,
    input wire logic wake
);
    logic [7:0] tc_ff;
    logic [7:0] gc_ff;
    logic [3:0] gv;
    logic act;
    logic act_ff;
    logic [4:0] st_ff;
    logic rl;
    logic base;
    logic gbase;
    assign rl = bus_req.rd && bus_req.addr == ADDR_COUNTER_LOW;
    assign base = tc_ff[0] && !tc_ff[3] && !gc_ff[7];
    assign gbase = gc_ff[7] && tc_ff[5:0] == 6'h01;
    assign gv = {gate_in.watchdog_ovf, gate_in.period_timer_match,
                 gate_in.eight_bit_timer_ovf, gate_in.gate_pin};
    assign act = gv[gc_ff[1:0]] == gc_ff[6];
    // Shadow copies of the control registers, so windows know the mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            tc_ff <= 8'h00;
            gc_ff <= 8'h00;
        end else if (bus_req.wr && bus_req.addr == ADDR_TIMER_CONTROL) begin
            tc_ff <= bus_req.wdata;
        end else if (bus_req.wr && bus_req.addr == ADDR_GATE_CONTROL) begin
            gc_ff <= bus_req.wdata;
        end
    end
    // Cycles the gate has kept its level; covers the pin synchroniser delay.
    always_ff @(posedge clk) begin
        act_ff <= act;
        if (rst || act != act_ff || (bus_req.wr && bus_req.addr == ADDR_GATE_CONTROL)) begin
            st_ff <= 5'h00;
        end else if (st_ff != 5'h1F) begin
            st_ff <= st_ff + 5'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_wake_level: assert property (wake == (overflow_flag && sleep))
        else $error("wake level wrong");
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_flag_sticky: assert property (overflow_flag && !(bus_req.wr &&
        bus_req.addr == ADDR_STATUS && bus_req.wdata[0]) |=> overflow_flag)
        else $error("overflow flag dropped");
    chk_div_one: assert property (rl && base && tc_ff[5:4] == 2'h0 ##1 rl
        |=> rdata == $past(rdata) + 8'h01) else $error("divide by one wrong");
    // Windows only count when no register write falls between the two reads.
    chk_div_two: assert property (rl && base && tc_ff[5:4] == 2'h1
        ##1 !bus_req.wr ##1 rl
        |=> rdata == $past(rdata, 2) + 8'h01) else $error("divide by two wrong");
    chk_div_eight: assert property (rl && base && tc_ff[5:4] == 2'h3
        ##1 (!bus_req.wr)[*7] ##1 rl
        |=> rdata == $past(rdata, 8) + 8'h01) else $error("divide by eight wrong");
    chk_gate_hold: assert property (rl && gbase && !act && st_ff > 5'h05
        ##1 (!bus_req.wr)[*7] ##1 rl && !act && st_ff > 5'h0D
        |=> rdata == $past(rdata, 8))
        else $error("count moved with gate inactive");
    chk_gate_count: assert property (rl && gbase && act && st_ff > 5'h05
        ##1 (!bus_req.wr)[*7] ##1 rl && act && st_ff > 5'h0D
        |=> rdata == $past(rdata, 8) + 8'h08)
        else $error("count stalled with gate active");
endmodule

// file: tb/gsbt_partner.sv
// Model of the external count clock that feeds the timer.
`timescale 1ns/1ps
module gsbt_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] half,
    output logic ext_clk,
    output logic [7:0] edges
);
    logic [2:0] cnt_ff;
    // The clock only stops once low, so no short high phase ends a burst.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 3'h0;
            ext_clk <= 1'b0;
            edges <= 8'h00;
        end else if (!run && !ext_clk) begin
            cnt_ff <= 3'h0;
        end else if (cnt_ff == half - 3'h1) begin
            cnt_ff <= 3'h0;
            ext_clk <= !ext_clk;
            edges <= edges + {7'h00, !ext_clk};
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
endmodule

// file: tb/gsbt_timer_tb.sv
// Self-checking bench for the gated sixteen-bit timer.
`timescale 1ns/1ps
module gsbt_timer_tb
    import gsbt_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    logic run = 1'b0;
    logic [2:0] half = 3'h3;
    gsbt_bus_req_t bus_req = '0;
    gsbt_gate_in_t gate_in = '0;
    logic [7:0] rdata, edges, v0, v1, t, e0, m;
    logic ext_clk, overflow_flag, wake;
    logic [3:0] gv;
    logic [31:0] seed = 32'h2BB0;
    int errors = 0, samples_checked = 0, cyc = 0;
    always #10 clk = ~clk;
    gsbt_timer dut (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .counter_clock_source(ext_clk), .gate_in(gate_in), .sleep(sleep),
        .overflow_flag(overflow_flag), .wake(wake));
    gsbt_partner far (.clk(clk), .rst(rst), .run(run), .half(half),
        .ext_clk(ext_clk), .edges(edges));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [7:0] gate_exp(input logic lv, input logic pol);
        return (lv == pol) ? 8'h08 : 8'h00;
    endfunction
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    // Two reads of one address, gap cycles apart; gap 0 gives one read in y.
    task automatic rd(input logic [3:0] a, input int gap, output logic [7:0] x, y);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        for (int i = 1; i <= gap; i++) begin
            @(posedge clk);
            bus_req.rd <= (i == gap);
            if (i == 1) begin
                #1 x = rdata;
            end
        end
        @(posedge clk);
        bus_req <= '0;
        #1 y = rdata;
    endtask
    task automatic final_report;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            rd(4'(a == 5 ? 15 : a), 0, t, v1);
            chk("reset value", v1, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            seed = lfsr(seed);
            m = 8'h01 + {4'h0, seed[11:8]};
            wr(ADDR_TIMER_CONTROL, {2'h0, 2'(p), 4'h1});
            rd(ADDR_COUNTER_LOW, 1 << p, v0, v1);
            chk("prescale period", v1 - v0, 8'h01);
            rd(ADDR_COUNTER_LOW, (1 << p) * int'(m), v0, v1);
            chk("prescale span", v1 - v0, m);
        end
        // Stopped, cleared by a byte write, restarted: first divide-by-eight tick is 8 edges on.
        wr(ADDR_TIMER_CONTROL, 8'h30);
        wr(ADDR_COUNTER_LOW, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h31);
        rd(ADDR_COUNTER_LOW, 6, v0, v1);
        chk("prescale clear start", v0, 8'h00);
        chk("prescale clear early", v1, 8'h00);
        rd(ADDR_COUNTER_LOW, 0, t, v1);
        chk("prescale clear tick", v1, 8'h01);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_COUNTER_LOW, 8'hFD);
        wr(ADDR_COUNTER_HIGH, 8'hFF);
        rd(ADDR_COUNTER_LOW, 0, t, v1);
        chk("counter low write", v1, 8'hFD);
        sleep <= 1'b1;
        wr(ADDR_TIMER_CONTROL, 8'h01);
        repeat (6) @(posedge clk);
        #1 chk("overflow flag", 8'(overflow_flag), 8'h01);
        chk("wake", 8'(wake), 8'h01);
        rd(ADDR_COUNTER_HIGH, 0, t, v1);
        chk("wrap high", v1, 8'h00);
        wr(ADDR_STATUS, 8'h01);
        #1 chk("flag clear", 8'(overflow_flag), 8'h00);
        sleep <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            seed = lfsr(seed);
            gv = {4{!seed[16]}};
            gv[3 - s % 4] = seed[16];
            gate_in <= gv;
            wr(ADDR_GATE_CONTROL, {1'b1, 1'(s >> 2), 4'h0, 2'(s)});
            repeat (8) @(posedge clk);
            rd(ADDR_COUNTER_LOW, 8, v0, v1);
            chk("gated count", v1 - v0, gate_exp(seed[16], 1'(s >> 2)));
        end
        wr(ADDR_GATE_CONTROL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            half <= 3'h3 + {1'b0, seed[18:17]};
            sleep <= 1'(k);
            wr(ADDR_TIMER_CONTROL, k == 1 ? 8'h0D : 8'h09);
            rd(ADDR_COUNTER_LOW, 0, t, v0);
            e0 = edges;
            run <= 1'b1;
            repeat (60) @(posedge clk);
            run <= 1'b0;
            repeat (20) @(posedge clk);
            rd(ADDR_COUNTER_LOW, 0, t, v1);
            chk("external count", v1 - v0, edges - e0);
        end
        final_report;
    end
endmodule
bind gsbt_timer gsbt_monitor mon (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .gate_in(gate_in), .sleep(sleep), .overflow_flag(overflow_flag), .wake(wake));
